// ===== sdt_pkg.sv
// shared constants, register map and carrier types of the standard timer
package sdt_pkg;

    // ========================================
    // register map (byte index on the register port)
    localparam logic [2:0] ADDR_RUN_CLOCK_CTRL = 3'h0;
    localparam logic [2:0] ADDR_MODE_OUTPUT_CTRL = 3'h1;
    localparam logic [2:0] ADDR_COUNTER_LOW = 3'h2;
    localparam logic [2:0] ADDR_COUNTER_HIGH = 3'h3;
    localparam logic [2:0] ADDR_COMPARE_A_LOW = 3'h4;
    localparam logic [2:0] ADDR_COMPARE_A_HIGH = 3'h5;
    localparam logic [2:0] ADDR_COMPARE_P = 3'h6;

    // ========================================
    // field positions and reset values
    localparam int PAUSE_BIT_POS = 7;
    localparam int RUN_BIT_POS = 3;
    localparam logic [7:0] RUN_CLOCK_CTRL_MASK = 8'hf8;
    localparam logic [7:0] RUN_CLOCK_CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_OUTPUT_CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_A_RESET = 16'h0000;
    localparam logic [7:0] COMPARE_P_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ========================================
    // clock source codes and prescaler ratios
    localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CLK_SYS = 3'h1;
    localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
    localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
    localparam logic [2:0] CLK_SUB_A = 3'h4;
    localparam logic [2:0] CLK_SUB_B = 3'h5;
    localparam logic [2:0] CLK_EXT_RISE = 3'h6;
    localparam logic [2:0] CLK_EXT_FALL = 3'h7;
    localparam int SYS_DIV = 4;
    localparam int HIGH_DIV_SHORT = 16;
    localparam int HIGH_DIV_LONG = 64;

    // ========================================
    // pin function codes
    localparam logic [1:0] PF_CMP_NONE = 2'h0;
    localparam logic [1:0] PF_CMP_LOW = 2'h1;
    localparam logic [1:0] PF_CMP_HIGH = 2'h2;
    localparam logic [1:0] PF_CMP_TOGGLE = 2'h3;
    localparam logic [1:0] PF_PWM_INACTIVE = 2'h0;
    localparam logic [1:0] PF_PWM_ACTIVE = 2'h1;
    localparam logic [1:0] PF_PWM_WAVE = 2'h2;
    localparam logic [1:0] PF_PWM_SINGLE = 2'h3;
    localparam logic [1:0] PF_CAP_RISE = 2'h0;
    localparam logic [1:0] PF_CAP_FALL = 2'h1;
    localparam logic [1:0] PF_CAP_BOTH = 2'h2;
    localparam logic [1:0] PF_CAP_OFF = 2'h3;

    typedef enum logic [1:0] {
        MODE_COMPARE,
        MODE_CAPTURE,
        MODE_PWM,
        MODE_TIMER
    } sdt_mode_t;

    typedef struct packed {
        logic pause_bit;
        logic [2:0] clock_select;
        logic counter_run_bit;
        logic [2:0] unused;
    } sdt_run_clock_t;

    typedef struct packed {
        logic [1:0] mode_select;
        logic [1:0] pin_function_select;
        logic output_initial_level;
        logic output_invert;
        logic duty_period_swap;
        logic clear_select;
    } sdt_mode_output_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sdt_bus_req_t;

endpackage : sdt_pkg

// ===== sdt_clk_src.sv
// counter clock source selection, prescalers and external clock pin synchroniser
module sdt_clk_src (
    // clock and reset
    input logic i_core_clk,
    input logic i_sys_rst,
    // source selection and rate ticks
    input logic [2:0] i_clock_select,
    input logic i_high_tick,
    input logic i_sub_tick,
    // external clock pin
    input logic i_ext_clock_pin,
    // one-cycle count tick
    output logic o_tick
);

    // ========================================
    // prescalers
    logic [1:0] sys_div;
    logic [5:0] high_div;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic next_tick;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            sys_div <= 2'h0;
        end else begin
            sys_div <= sys_div + 2'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            high_div <= 6'h00;
        end else if (i_high_tick) begin
            high_div <= high_div + 6'h01;
        end
    end

    // ========================================
    // external pin: two flops before any edge logic
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= i_ext_clock_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // ========================================
    // source mux
    always_comb begin
        case (i_clock_select)
            sdt_pkg::CLK_SYS_DIV4: next_tick = (sys_div == 2'(sdt_pkg::SYS_DIV - 1));
            sdt_pkg::CLK_SYS: next_tick = 1'b1;
            sdt_pkg::CLK_HIGH_DIV16: next_tick = i_high_tick && (high_div[3:0] == 4'(sdt_pkg::HIGH_DIV_SHORT - 1));
            sdt_pkg::CLK_HIGH_DIV64: next_tick = i_high_tick && (high_div == 6'(sdt_pkg::HIGH_DIV_LONG - 1));
            sdt_pkg::CLK_SUB_A: next_tick = i_sub_tick;
            sdt_pkg::CLK_SUB_B: next_tick = i_sub_tick;
            sdt_pkg::CLK_EXT_RISE: next_tick = ext_s2 && !ext_s3;
            default: next_tick = !ext_s2 && ext_s3;
        endcase
    end

    // registered so the counter sees a clean single-cycle enable
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= next_tick;
        end
    end

endmodule : sdt_clk_src

// ===== sdt_timer.sv
// standard timer core: counter, comparators, output pin, capture and register port
//
// Implementation choices: the placing of the registers and the plain strobed port.

module sdt_timer (
    // clock and reset
    input logic i_core_clk,
    input logic i_sys_rst,
    // register port
    input sdt_pkg::sdt_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    // clock rate ticks
    input logic i_high_tick,
    input logic i_sub_tick,
    // pins
    input logic i_ext_clock_pin,
    input logic i_capture_pin,
    output logic o_timer_output_pin,
    output logic o_timer_output_inverse_pin,
    // match events
    output logic o_match_a_event,
    output logic o_match_p_event
);

    // ========================================
    // state
    sdt_pkg::sdt_run_clock_t run_ctrl;
    sdt_pkg::sdt_mode_output_t mode_ctrl;
    sdt_pkg::sdt_mode_t mode;
    logic [15:0] counter;
    logic [15:0] compare_a_value;
    logic [7:0] compare_p_value;
    logic [7:0] byte_buf;
    logic run_prev;
    logic pulse_done;
    logic out_level;
    logic cap_s1;
    logic cap_s2;
    logic cap_s3;
    logic tick;
    logic run_rise;
    logic count_en;
    logic [15:0] next_count;
    logic hit_a;
    logic hit_p;
    logic clear_now;
    logic cap_edge;
    logic a_event;
    logic p_event;
    logic period_hit;
    logic duty_hit;

    // ========================================
    // comparator functions
    function automatic logic match_p(input logic [15:0] value, input logic [7:0] top);
        // zero compares against the wrap to zero, which is the counter overflow
        match_p = (top == 8'h00) ? (value == 16'h0000) : (value == {top, 8'h00});
    endfunction : match_p

    function automatic logic match_a(input logic [15:0] value, input logic [15:0] full);
        // an all-zero compare value never matches; the counter just overflows
        match_a = (full != 16'h0000) && (value == full);
    endfunction : match_a

    // ========================================
    // clock source
    sdt_clk_src u_clk_src (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clock_select(run_ctrl.clock_select),
        .i_high_tick(i_high_tick),
        .i_sub_tick(i_sub_tick),
        .i_ext_clock_pin(i_ext_clock_pin),
        .o_tick(tick)
    );

    assign mode = sdt_pkg::sdt_mode_t'(mode_ctrl.mode_select);
    assign run_rise = run_ctrl.counter_run_bit && !run_prev;
    assign count_en = tick && run_ctrl.counter_run_bit && !run_ctrl.pause_bit && !pulse_done;
    assign next_count = counter + 16'h0001;
    assign hit_a = count_en && match_a(next_count, compare_a_value);
    assign hit_p = count_en && match_p(next_count, compare_p_value);
    assign period_hit = mode_ctrl.duty_period_swap ? hit_a : hit_p;
    assign duty_hit = mode_ctrl.duty_period_swap ? hit_p : hit_a;

    // ========================================
    // clear condition and events
    always_comb begin
        case (mode)
            sdt_pkg::MODE_PWM: clear_now = period_hit;
            sdt_pkg::MODE_CAPTURE: clear_now = hit_p;
            default: clear_now = mode_ctrl.clear_select ? hit_a : hit_p;
        endcase
    end

    always_comb begin
        case (mode)
            sdt_pkg::MODE_CAPTURE: begin
                a_event = cap_edge;
                p_event = hit_p;
            end
            sdt_pkg::MODE_PWM: begin
                a_event = hit_a;
                p_event = hit_p;
            end
            default: begin
                a_event = hit_a;
                p_event = hit_p && !mode_ctrl.clear_select;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_match_a_event <= 1'b0;
            o_match_p_event <= 1'b0;
        end else begin
            o_match_a_event <= a_event;
            o_match_p_event <= p_event;
        end
    end

    // ========================================
    // counter
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            run_prev <= 1'b0;
        end else begin
            run_prev <= run_ctrl.counter_run_bit;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            counter <= sdt_pkg::COUNTER_RESET;
        end else if (run_rise) begin
            counter <= sdt_pkg::COUNTER_RESET;
        end else if (count_en) begin
            counter <= clear_now ? sdt_pkg::COUNTER_RESET : next_count;
        end
    end

    // single pulse stops the count at its trailing edge until the next run rise
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pulse_done <= 1'b0;
        end else if (run_rise) begin
            pulse_done <= 1'b0;
        end else if (mode == sdt_pkg::MODE_PWM && mode_ctrl.pin_function_select == sdt_pkg::PF_PWM_SINGLE && hit_a) begin
            pulse_done <= 1'b1;
        end
    end

    // ========================================
    // capture pin
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cap_s3 <= 1'b0;
        end else begin
            cap_s1 <= i_capture_pin;
            cap_s2 <= cap_s1;
            cap_s3 <= cap_s2;
        end
    end

    always_comb begin
        case (mode_ctrl.pin_function_select)
            sdt_pkg::PF_CAP_RISE: cap_edge = cap_s2 && !cap_s3;
            sdt_pkg::PF_CAP_FALL: cap_edge = !cap_s2 && cap_s3;
            sdt_pkg::PF_CAP_BOTH: cap_edge = cap_s2 != cap_s3;
            default: cap_edge = 1'b0;
        endcase
        if (mode != sdt_pkg::MODE_CAPTURE || !run_ctrl.counter_run_bit) begin
            cap_edge = 1'b0;
        end
    end

    // ========================================
    // output pin
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            out_level <= 1'b0;
        end else if (run_rise && mode != sdt_pkg::MODE_TIMER && mode != sdt_pkg::MODE_CAPTURE) begin
            out_level <= mode_ctrl.output_initial_level;
        end else begin
            case (mode)
                sdt_pkg::MODE_COMPARE: begin
                    // a request equal to the present level simply rewrites it
                    if (hit_a) begin
                        case (mode_ctrl.pin_function_select)
                            sdt_pkg::PF_CMP_LOW: out_level <= 1'b0;
                            sdt_pkg::PF_CMP_HIGH: out_level <= 1'b1;
                            sdt_pkg::PF_CMP_TOGGLE: out_level <= !out_level;
                            default: out_level <= out_level;
                        endcase
                    end
                end
                sdt_pkg::MODE_PWM: begin
                    case (mode_ctrl.pin_function_select)
                        sdt_pkg::PF_PWM_INACTIVE: out_level <= !mode_ctrl.output_initial_level;
                        sdt_pkg::PF_PWM_ACTIVE: out_level <= mode_ctrl.output_initial_level;
                        sdt_pkg::PF_PWM_WAVE: begin
                            if (duty_hit) begin
                                out_level <= !mode_ctrl.output_initial_level;
                            end else if (period_hit) begin
                                out_level <= mode_ctrl.output_initial_level;
                            end
                        end
                        default: begin
                            if (hit_a) begin
                                out_level <= !mode_ctrl.output_initial_level;
                            end
                        end
                    endcase
                end
                default: out_level <= out_level;
            endcase
        end
    end

    // inversion is skipped in timer mode, where the pin carries no meaning
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_timer_output_pin <= 1'b0;
            o_timer_output_inverse_pin <= 1'b1;
        end else if (mode == sdt_pkg::MODE_TIMER) begin
            o_timer_output_pin <= out_level;
            o_timer_output_inverse_pin <= !out_level;
        end else begin
            o_timer_output_pin <= out_level ^ mode_ctrl.output_invert;
            o_timer_output_inverse_pin <= !(out_level ^ mode_ctrl.output_invert);
        end
    end

    // ========================================
    // register writes
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            run_ctrl <= sdt_pkg::RUN_CLOCK_CTRL_RESET;
            mode_ctrl <= sdt_pkg::MODE_OUTPUT_CTRL_RESET;
            compare_p_value <= sdt_pkg::COMPARE_P_RESET;
        end else if (i_bus.wr) begin
            if (i_bus.addr == sdt_pkg::ADDR_RUN_CLOCK_CTRL) begin
                run_ctrl <= i_bus.wdata & sdt_pkg::RUN_CLOCK_CTRL_MASK;
            end else if (i_bus.addr == sdt_pkg::ADDR_MODE_OUTPUT_CTRL) begin
                mode_ctrl <= i_bus.wdata;
            end else if (i_bus.addr == sdt_pkg::ADDR_COMPARE_P) begin
                compare_p_value <= i_bus.wdata;
            end
        end
    end

    // capture outranks a software write landing in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            compare_a_value <= sdt_pkg::COMPARE_A_RESET;
        end else if (cap_edge) begin
            compare_a_value <= counter;
        end else if (i_bus.wr && i_bus.addr == sdt_pkg::ADDR_COMPARE_A_HIGH) begin
            compare_a_value <= {i_bus.wdata, byte_buf};
        end
    end

    // one buffer serves both byte pairs, so pair accesses must not interleave
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            byte_buf <= 8'h00;
        end else if (i_bus.wr && i_bus.addr == sdt_pkg::ADDR_COMPARE_A_LOW) begin
            byte_buf <= i_bus.wdata;
        end else if (i_bus.rd && i_bus.addr == sdt_pkg::ADDR_COUNTER_HIGH) begin
            byte_buf <= counter[7:0];
        end else if (i_bus.rd && i_bus.addr == sdt_pkg::ADDR_COMPARE_A_HIGH) begin
            byte_buf <= compare_a_value[7:0];
        end
    end

    // ========================================
    // register reads, data in the following cycle only
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_rdata <= sdt_pkg::READ_UNMAPPED;
        end else if (!i_bus.rd) begin
            o_rdata <= sdt_pkg::READ_UNMAPPED;
        end else if (i_bus.addr == sdt_pkg::ADDR_RUN_CLOCK_CTRL) begin
            o_rdata <= run_ctrl & sdt_pkg::RUN_CLOCK_CTRL_MASK;
        end else if (i_bus.addr == sdt_pkg::ADDR_MODE_OUTPUT_CTRL) begin
            o_rdata <= mode_ctrl;
        end else if (i_bus.addr == sdt_pkg::ADDR_COUNTER_LOW || i_bus.addr == sdt_pkg::ADDR_COMPARE_A_LOW) begin
            o_rdata <= byte_buf;
        end else if (i_bus.addr == sdt_pkg::ADDR_COUNTER_HIGH) begin
            o_rdata <= counter[15:8];
        end else if (i_bus.addr == sdt_pkg::ADDR_COMPARE_A_HIGH) begin
            o_rdata <= compare_a_value[15:8];
        end else if (i_bus.addr == sdt_pkg::ADDR_COMPARE_P) begin
            o_rdata <= compare_p_value;
        end else begin
            o_rdata <= sdt_pkg::READ_UNMAPPED;
        end
    end

    // ========================================
    // checks
    sequence s_counter_zeroed;
        ##1 (counter == 16'h0000);
    endsequence

    sequence s_high_write;
        i_bus.wr && i_bus.addr == sdt_pkg::ADDR_COMPARE_A_HIGH && !cap_edge;
    endsequence

    run_clear_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        run_rise |-> s_counter_zeroed) else $error("run rise did not clear counter");

    pause_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (run_ctrl.pause_bit && !run_rise) |=> $stable(counter)) else $error("counter moved while paused");

    sw_no_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_bus.wr && !count_en && !run_rise) |=> $stable(counter)) else $error("software write changed counter");

    clear_match_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (clear_now && !run_rise) |-> s_counter_zeroed) else $error("match did not clear counter");

    ctrl0_zero_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == sdt_pkg::ADDR_RUN_CLOCK_CTRL) |=> (o_rdata[2:0] == 3'h0))
        else $error("unimplemented bits read nonzero");

    pair_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        s_high_write |=> (compare_a_value == {$past(i_bus.wdata), $past(byte_buf)}))
        else $error("high write did not load both bytes");

    pair_read_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == sdt_pkg::ADDR_COUNTER_HIGH) ##1 (i_bus.rd && i_bus.addr == sdt_pkg::ADDR_COUNTER_LOW)
        |=> (o_rdata == $past(counter[7:0], 2))) else $error("low read did not return latched byte");

    a_event_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        a_event |=> o_match_a_event) else $error("comparator A event lost");

    init_level_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (run_rise && (mode == sdt_pkg::MODE_COMPARE || mode == sdt_pkg::MODE_PWM))
        |=> (out_level == $past(mode_ctrl.output_initial_level))) else $error("output not at initial level");

    capture_copy_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        cap_edge |=> (compare_a_value == $past(counter)) && o_match_a_event)
        else $error("capture did not copy counter");

    invert_pin_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (mode != sdt_pkg::MODE_TIMER) |=> (o_timer_output_pin == ($past(out_level) ^ $past(mode_ctrl.output_invert))))
        else $error("output inversion wrong");

endmodule : sdt_timer

// ===== sdt_pin_model.sv
// pin-side model: external count clock and capture input
module sdt_pin_model (
    // clock
    input wire logic i_clk,
    // pins
    output logic o_ext_clock_pin,
    output logic o_capture_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_ext_clock_pin = 1'b0;
        o_capture_pin = 1'b0;
    end
    // high level held four cycles and low level five, so the synchroniser sees each one
    task pulse(input int n);
        repeat (n) begin
            @(posedge i_clk) o_ext_clock_pin <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_ext_clock_pin <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask : pulse
    task flip;
        @(posedge i_clk) o_capture_pin <= ~o_capture_pin;
    endtask : flip
endmodule : sdt_pin_model

// ===== standard_timer_module_tb.sv
// self-checking bench for the standard timer core
module standard_timer_module_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    sdt_pkg::sdt_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic ext, cap, pin, pin_n, ev_a, ev_p, pp;
    logic [7:0] q, q2, ne, nt;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    sdt_timer sdt_timer_i (.i_core_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_rdata(rdata),
        .i_high_tick(1'b1), .i_sub_tick(1'b0), .i_ext_clock_pin(ext), .i_capture_pin(cap),
        .o_timer_output_pin(pin), .o_timer_output_inverse_pin(pin_n), .o_match_a_event(ev_a),
        .o_match_p_event(ev_p));
    sdt_pin_model sdt_pin_model_i (.i_clk(clk), .o_ext_clock_pin(ext), .o_capture_pin(cap));
    // ========
    // tasks
    task stop_test;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one bus cycle; read data taken in the cycle after the strobe only
    task acc(input logic [2:0] a, input logic [7:0] d, input logic w);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
        @(posedge clk);
        bus <= '0;
        #1 q = rdata;
    endtask : acc
    task rc(input logic [2:0] a, input logic [7:0] e);
        acc(a, 8'h00, 1'b0);
        chk(q, e);
    endtask : rc
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    // ========
    // tests
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rc(3'h1, 8'h00);
        rc(3'h7, 8'h00);
        acc(3'h0, 8'h07, 1'b1);
        rc(3'h0, 8'h00);
        acc(3'h4, 8'h03, 1'b1);
        rc(3'h5, 8'h00);
        rc(3'h4, 8'h00);
        acc(3'h4, 8'h03, 1'b1);
        acc(3'h5, 8'h00, 1'b1);
        rc(3'h5, 8'h00);
        rc(3'h4, 8'h03);
        acc(3'h1, 8'h31, 1'b1);
        acc(3'h0, 8'h18, 1'b1);
        repeat (10) @(posedge clk);
        ne = '0;
        nt = '0;
        pp = pin;
        repeat (30) begin
            @(posedge clk);
            #1;
            if (ev_a === 1'b1) ne++;
            if (pin !== pp) nt++;
            pp = pin;
        end
        chk(ne, 8'h0a);
        chk(nt, 8'h0a);
        chk({7'h00, pin_n}, {7'h00, !pin});
        acc(3'h0, 8'h00, 1'b1);
        acc(3'h1, 8'h00, 1'b1);
        acc(3'h2, 8'h55, 1'b1);
        acc(3'h0, 8'h18, 1'b1);
        repeat (20) @(posedge clk);
        acc(3'h0, 8'h98, 1'b1);
        acc(3'h3, 8'h00, 1'b0);
        acc(3'h2, 8'h00, 1'b0);
        q2 = q;
        repeat (10) @(posedge clk);
        rc(3'h3, 8'h00);
        rc(3'h2, q2);
        acc(3'h0, 8'h90, 1'b1);
        acc(3'h0, 8'h98, 1'b1);
        rc(3'h3, 8'h00);
        rc(3'h2, 8'h00);
        acc(3'h0, 8'h60, 1'b1);
        acc(3'h0, 8'h68, 1'b1);
        sdt_pin_model_i.pulse(5);
        repeat (8) @(posedge clk);
        rc(3'h3, 8'h00);
        rc(3'h2, 8'h05);
        acc(3'h0, 8'h60, 1'b1);
        acc(3'h1, 8'h40, 1'b1);
        acc(3'h0, 8'h68, 1'b1);
        sdt_pin_model_i.pulse(4);
        sdt_pin_model_i.flip();
        repeat (8) @(posedge clk);
        rc(3'h5, 8'h00);
        rc(3'h4, 8'h04);
        // pwm: period from P (256 ticks), duty from the captured A value of 4
        acc(3'h0, 8'h60, 1'b1);
        acc(3'h1, 8'ha8, 1'b1);
        acc(3'h6, 8'h01, 1'b1);
        acc(3'h0, 8'h18, 1'b1);
        ne = '0;
        nt = '0;
        pp = pin;
        repeat (600) begin
            @(posedge clk);
            #1;
            if (ev_p === 1'b1) ne++;
            if (pin !== pp) nt++;
            pp = pin;
        end
        chk(ne, 8'h02);
        chk(nt, 8'h06);
        stop_test();
    end
endmodule : standard_timer_module_tb
